//--- chan_flag_pkg.sv
// package: constants and types for the timer channel flag block
package chan_flag_pkg;

  // channel mode field
  localparam int MODE_W = 3;
  typedef enum logic [MODE_W-1:0] {
    MODE_GPIO_IN  = 3'h0,
    MODE_GPIO_OUT = 3'h1,
    MODE_MCB_UP   = 3'h2,
    MODE_MCB_UPDN = 3'h3
  } chan_mode_t;

  // counter width and reset values
  localparam int          CNT_W          = 16;
  localparam logic [15:0] PERIOD_RST     = 16'hFFFF;
  localparam logic [15:0] CNT_RST        = 16'h0000;
  localparam chan_mode_t  MODE_RST       = MODE_GPIO_IN;
  localparam logic        ENABLE_RST     = 1'b0;
  localparam logic        DMA_SEL_RST    = 1'b0;

  // prescaler timing: counter tick period in ns at 50 MHz
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_NS = 80;
  localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W          = 4;

endpackage : chan_flag_pkg

//--- period_buffer.sv
// module: buffered period register, read data out of a flop
`timescale 1ns/100ps
module period_buffer (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstSync_n,
  // write side
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  // load side
  input  wire logic        loadEn,
  output logic      [15:0] active_r
);
  import chan_flag_pkg::*;

  logic [15:0] shadow_r;
  logic [15:0] shadow_nxt;
  logic [15:0] active_nxt;

  always_comb begin
    shadow_nxt = wrEn ? wrData : shadow_r;
    active_nxt = loadEn ? shadow_r : active_r;
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      shadow_r <= PERIOD_RST;
      active_r <= PERIOD_RST;
    end else begin
      shadow_r <= shadow_nxt;
      active_r <= active_nxt;
    end
  end

endmodule : period_buffer

//--- timer_channel_flag.sv
// module: one timer channel with status flag and request gating
//
// Contract
// - Moving the mode from general-purpose I/O to buffered modulus-counter mode may set the flag with no counter event.
// - A set flag raises the interrupt or DMA request whenever the flag request enable is set.
// - A one written to the flag clears it unless a set event comes in the same cycle, a zero leaves it unchanged.
// - With the flag request enable clear no interrupt or DMA request is issued, even if the flag is set.
`timescale 1ns/100ps
module timer_channel_flag (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // channel control
  input  wire chan_flag_pkg::chan_mode_t  modeSel,
  input  wire logic                       flag_request_enable,
  input  wire logic                       dmaSelect,
  input  wire logic                       periodWrite,
  input  wire logic [15:0]                periodData,
  // status
  input  wire logic                       flagClearWrite,
  input  wire logic                       flagClearData,
  output logic                            channelFlag,
  output logic [15:0]                     counterValue,
  // requests
  output logic                            irqReq,
  output logic                            dmaReq
);
  import chan_flag_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rstSync_r;
  logic       rstSync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstSync_r[1];

  // ****************************************
  // tick divider
  // ****************************************
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] pre_nxt;
  logic             tick;

  always_comb begin
    tick    = (pre_r == PRE_W'(TICK_CYCLES - 1));
    pre_nxt = tick ? '0 : pre_r + PRE_W'(1);
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  // ****************************************
  // mode tracking and counter
  // ****************************************
  chan_mode_t  mode_r;
  chan_mode_t  mode_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        down_r;
  logic        down_nxt;
  logic [15:0] period;
  logic        isMcb;
  logic        wasGpio;
  logic        enterMcb;
  logic        cntEvent;

  period_buffer periodBuf (
    .ref_clk   (ref_clk),
    .rstSync_n (rstSync_n),
    .wrEn      (periodWrite),
    .wrData    (periodData),
    .loadEn    (cntEvent),
    .active_r  (period)
  );

  always_comb begin
    isMcb    = (modeSel == MODE_MCB_UP) || (modeSel == MODE_MCB_UPDN);
    wasGpio  = (mode_r == MODE_GPIO_IN) || (mode_r == MODE_GPIO_OUT);
    enterMcb = isMcb && wasGpio;
    mode_nxt = modeSel;
    cnt_nxt  = cnt_r;
    down_nxt = down_r;
    cntEvent = 1'b0;
    if (enterMcb) begin
      cnt_nxt  = CNT_RST;
      down_nxt = 1'b0;
    end else if (isMcb && tick) begin
      case (modeSel)
        MODE_MCB_UP: begin
          if (cnt_r >= period) begin
            cnt_nxt  = CNT_RST;
            cntEvent = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
        MODE_MCB_UPDN: begin
          if (!down_r && cnt_r >= period) begin
            down_nxt = 1'b1;
            cnt_nxt  = cnt_r - 16'h0001;
          end else if (down_r && cnt_r == 16'h0000) begin
            down_nxt = 1'b0;
            cntEvent = 1'b1;
            cnt_nxt  = 16'h0001;
          end else begin
            cnt_nxt = down_r ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      mode_r <= MODE_RST;
      cnt_r  <= CNT_RST;
      down_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cnt_r  <= cnt_nxt;
      down_r <= down_nxt;
    end
  end

  // ****************************************
  // status flag and requests
  // ****************************************
  logic flag_r;
  logic flag_nxt;
  logic irq_r;
  logic irq_nxt;
  logic dma_r;
  logic dma_nxt;
  logic flagSet;

  always_comb begin
    flagSet = cntEvent || enterMcb;
    flag_nxt = flag_r;
    if (flagClearWrite && flagClearData) begin
      flag_nxt = 1'b0;
    end
    if (flagSet) begin
      flag_nxt = 1'b1;
    end
    irq_nxt = flag_nxt && flag_request_enable && !dmaSelect;
    dma_nxt = flag_nxt && flag_request_enable && dmaSelect;
  end

  always_ff @(posedge ref_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      flag_r <= 1'b0;
      irq_r  <= 1'b0;
      dma_r  <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r  <= irq_nxt;
      dma_r  <= dma_nxt;
    end
  end

  assign channelFlag  = flag_r;
  assign counterValue = cnt_r;
  assign irqReq       = irq_r;
  assign dmaReq       = dma_r;

endmodule : timer_channel_flag

//--- timer_channel_flag_asserts.sv
// checker: flag and request assertions for the timer channel
`timescale 1ns/100ps
module timer_channel_flag_asserts (
  // clock, reset, watched ports
  input wire logic                      ref_clk,
  input wire logic                      rst_n,
  input wire chan_flag_pkg::chan_mode_t modeSel,
  input wire logic                      flag_request_enable,
  input wire logic                      dmaSelect,
  input wire logic                      flagClearWrite,
  input wire logic                      flagClearData,
  input wire logic                      channelFlag,
  input wire logic                      irqReq,
  input wire logic                      dmaReq
);
  import chan_flag_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_mode_switch_flag: assert property ($past(modeSel) <= MODE_GPIO_OUT && modeSel >= MODE_MCB_UP |=> channelFlag)
    else $error("flag not set on mode switch");
  a_irq_route: assert property (irqReq == (channelFlag && $past(flag_request_enable) && !$past(dmaSelect)))
    else $error("irq request wrong");
  a_dma_route: assert property (dmaReq == (channelFlag && $past(flag_request_enable) && $past(dmaSelect)))
    else $error("dma request wrong");
  a_clear_flag: assert property (flagClearWrite && flagClearData && $stable(modeSel) |=> !channelFlag)
    else $error("flag not cleared");
endmodule : timer_channel_flag_asserts
bind timer_channel_flag timer_channel_flag_asserts chk_u (.ref_clk, .rst_n, .modeSel, .flag_request_enable,
  .dmaSelect, .flagClearWrite, .flagClearData, .channelFlag, .irqReq, .dmaReq);

//--- tb_timer_channel_flag.sv
// testbench: workaround walk and random traffic for the timer channel
`timescale 1ns/100ps
module tb_timer_channel_flag;
  import chan_flag_pkg::*;
  logic       ref_clk, rst_n, flag_request_enable, dmaSelect, flagClearWrite, flagClearData;
  logic       channelFlag, irqReq, dmaReq;
  logic [15:0] counterValue;
  chan_mode_t modeSel;
  int         err_count, comparisons, fl, pm, r, seed;
  timer_channel_flag dut_u (.ref_clk, .rst_n, .modeSel, .flag_request_enable, .dmaSelect,
    .periodWrite(1'b0), .periodData(16'h0000), .flagClearWrite, .flagClearData, .channelFlag,
    .counterValue, .irqReq, .dmaReq);
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input int e, input logic g);
    comparisons++;
    if (g !== e[0]) begin
      err_count++;
      $display("BAD %s exp %0d got %b", n, e[0], g);
    end
  endtask : chk
  task automatic chk_cnt(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk_cnt
  // drive at falling edge, model the flag, compare at next falling edge
  task automatic step(input int m, e, d, c);
    logic ent;
    modeSel             = chan_mode_t'(m[2:0]);
    flag_request_enable = e[0];
    dmaSelect           = d[0];
    flagClearWrite      = c[0];
    flagClearData       = c[1];
    @(posedge ref_clk);
    ent = (pm < 2 && m >= 2);
    if (ent) fl = 1;
    else if (c == 3) fl = 0;
    pm = m;
    @(negedge ref_clk);
    chk("flag", fl, channelFlag);
    chk("irq", fl & e & ~d, irqReq);
    chk("dma", fl & e & d, dmaReq);
    if (ent) chk_cnt("counter", CNT_RST, counterValue);
  endtask : step
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
  initial begin
    {rst_n, flag_request_enable, dmaSelect, flagClearWrite, flagClearData} = 5'h00;
    modeSel = MODE_GPIO_IN;
    seed    = 32'h06BD4D05;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    step(0, 0, 0, 0);
    step(2, 0, 0, 0);
    step(2, 0, 0, 3);
    step(2, 1, 0, 0);
    step(1, 1, 1, 0);
    step(3, 1, 1, 1);
    step(0, 0, 1, 0);
    step(3, 0, 0, 3);
    $display("walk test done");
    repeat (2000) begin
      r = $random(seed);
      step(r[1:0], r[2], r[3], r[5:4]);
    end
    $display("random test done");
    report_and_stop();
  end
endmodule : tb_timer_channel_flag
